// File: shared/serial_port_defs.svh
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// register banks, carried in address bits 11:8
`define BANK_PERIPH      4'h4
`define BANK_SERIAL      4'h6

// register offsets, address bits 7:0
`define OFF_CORE_IRQ     8'h07
`define OFF_IRQ_FLAGS    8'h10
`define OFF_IRQ_ENABLES  8'h11
`define OFF_ADDR_RELOAD  8'h10
`define OFF_CTRL_ONE     8'h11
`define OFF_CTRL_TWO     8'h12
`define OFF_STATUS       8'h13
`define OFF_DATA_BUF     8'h14

// reset values
`define RST_BYTE         8'h00
`define FLAGS_IMPL_MASK  8'hEF

// irq flag / enable bits
`define IF_PORT          7
`define IF_COLLISION     6

// control one fields
`define C1_WRITE_COLLISION_FLAG          7
`define C1_OVF           6
`define C1_EN            5
`define C1_CKP           4

// control two fields
`define C2_GENERAL_CALL_ENABLE          7
`define C2_ACK_RECEIVED_STATUS       6
`define C2_ACK_VALUE_TO_SEND         5
`define C2_ACK_SEND_REQUEST         4
`define C2_RECEIVE_REQUEST_BIT          3
`define C2_PEN           2
`define C2_REPEAT_START_REQUEST_BIT          1
`define C2_SEN           0

// status fields
`define ST_DA            5
`define ST_STOP          4
`define ST_START         3
`define ST_RW            2
`define ST_UA            1
`define ST_BF            0

// mode select encodings
`define MODE_MASTER      4'h8
`define MODE_SLAVE10     4'h7
`define GEN_CALL_ADDR    8'h00

`endif

// File: shared/serial_port_pkg.sv
package serial_port_pkg;

	typedef enum logic [3:0] {
		MS_IDLE, MS_START1, MS_START2, MS_RS1, MS_RS_HW, MS_RS2, MS_RS3,
		MS_BIT_LO, MS_BIT_HW, MS_BIT_HI, MS_STOP1, MS_STOP_HW, MS_STOP2, MS_STOP3
	} master_state_e;

	typedef enum logic [1:0] {
		OP_TX, OP_RX, OP_ACK
	} master_op_e;

	typedef logic [7:0] byte_t;

endpackage

// File: src/clock_rate_generator.sv
`timescale 1ns/100ps
module clock_rate_generator (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       clk_en_i,
	// control
	input  wire logic       load_i,
	input  wire logic       tick_i,
	input  wire logic [6:0] reload_i,
	// expiry pulse
	output logic            expire_o
);

	logic [6:0] cnt_reg;
	logic       run_reg;
	logic       expire_reg;

	assign expire_o = expire_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg    <= 7'h00;
			run_reg    <= 1'h0;
			expire_reg <= 1'h0;
		end else if (clk_en_i) begin
			expire_reg <= 1'h0;
			if (load_i) begin
				cnt_reg <= reload_i;
				run_reg <= 1'h1;
			end else if (run_reg && tick_i) begin
				if (cnt_reg == 7'h00) begin
					run_reg    <= 1'h0;
					expire_reg <= 1'h1;
				end else begin
					cnt_reg <= cnt_reg - 7'h01;
				end
			end
		end
	end

endmodule

// File: src/i2c_master_general_call_brg.sv
// Design decision made here: strobed register access.
`timescale 1ns/100ps
// How it works
// - general call needs enable bit set
// - shift eight bits, compare own and call
// - call match loads buffer, flag ninth fall
// - ten-bit mode: call skips second half
// - sleep keeps receiving, wakes on byte
// - reset disables port, aborts transfer
// - start/stop seen cleared by disable
// - bus free: stop seen or neither
// - master flags every completed operation
// - foreign stop raises flag when idle
// - data line mismatch sets collision flag
// - master needs mode 1000 and enable
// - early buffer write dropped, write collision
// - master drives clock, start, stop
// - transmitter sends bytes, samples acknowledge
// - receiver clocks bytes, sends acknowledge
// - reload from low seven address bits
// - buffer write starts generator, then halts
// - acknowledge status sampled, flag ninth end
// - stop flag only after stop completes
// - generator counts down then halts
// - decrement on second and fourth phase
// - high-phase reload only when clock seen high
// - master encoding is binary 1000
// - start: check high, wait, low, wait
`include "serial_port_defs.svh"
module i2c_master_general_call_brg
	import serial_port_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        clk_en_i,
	// register port
	input  wire logic [11:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// processor power state
	input  wire logic        sleep_i,
	output logic             wake_o,
	// two-wire bus, open drain
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o
);

	byte_t         core_irq_reg, flags_reg, enables_reg, adr_reg;
	byte_t         ctl1_reg, ctl2_reg, stat_reg, buf_reg, rdata_reg;
	byte_t         shreg_reg, rsr_reg, rd_mux;
	master_state_e state_reg;
	master_op_e    op_reg;
	logic [3:0]    bit_cnt_reg, sl_cnt_reg;
	logic [1:0]    qph_reg;
	logic scl_m_reg, scl_s_reg, scl_d_reg, sda_m_reg, sda_s_reg, sda_d_reg;
	logic scl_drv_reg, sda_drv_reg, sda_oe_reg, wake_reg, ack_rcv_reg;
	logic done_reg, bcol_reg, brg_load_reg, bf_clr_reg, rx_load_reg;
	logic sl_active_reg, sl_addr_reg, sl_ack_reg, sl_rw_reg, sl_da_reg;
	logic sl_load_reg, sl_irq_reg, sl_ov_reg, sl_ua_reg;
	logic sel_ser, sel_per, wr_buf, rd_buf, wr_adr, wr_c1, wr_c2, wr_st;
	logic master_on, slave_on, req_busy, tx_ok, tx_go, bus_free, brg_exp;
	logic scl_rise, scl_fall, start_det, stop_det, own_m, gc_m, collide, chk_one;

	assign scl_o    = 1'h0;
	assign sda_o    = 1'h0;
	assign scl_oe_o = scl_drv_reg;
	assign sda_oe_o = sda_oe_reg;
	assign rdata_o  = rdata_reg;
	assign wake_o   = wake_reg;

	// register decode
	assign sel_ser = (addr_i[11:8] == `BANK_SERIAL);
	assign sel_per = (addr_i[11:8] == `BANK_PERIPH);
	assign wr_buf  = wr_i && sel_ser && (addr_i[7:0] == `OFF_DATA_BUF);
	assign rd_buf  = rd_i && sel_ser && (addr_i[7:0] == `OFF_DATA_BUF);
	assign wr_adr  = wr_i && sel_ser && (addr_i[7:0] == `OFF_ADDR_RELOAD);
	assign wr_c1   = wr_i && sel_ser && (addr_i[7:0] == `OFF_CTRL_ONE);
	assign wr_c2   = wr_i && sel_ser && (addr_i[7:0] == `OFF_CTRL_TWO);
	assign wr_st   = wr_i && sel_ser && (addr_i[7:0] == `OFF_STATUS);

	assign master_on = ctl1_reg[`C1_EN] && (ctl1_reg[3:0] == `MODE_MASTER);
	assign slave_on  = ctl1_reg[`C1_EN] && !master_on;
	assign req_busy  = |ctl2_reg[4:0] || done_reg || bcol_reg;
	assign tx_ok     = master_on && (state_reg == MS_IDLE) && !req_busy;
	assign tx_go     = wr_buf && tx_ok;
	assign bus_free  = stat_reg[`ST_STOP] || !(stat_reg[`ST_START] || stat_reg[`ST_STOP]);

	// bus line sampling; the first stage feeds only the second
	assign scl_rise  = scl_s_reg && !scl_d_reg;
	assign scl_fall  = !scl_s_reg && scl_d_reg;
	assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
	assign stop_det  = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
			{sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
			qph_reg <= 2'h0;
		end else if (clk_en_i) begin
			scl_m_reg <= scl_i;
			scl_s_reg <= scl_m_reg;
			scl_d_reg <= scl_s_reg;
			sda_m_reg <= sda_i;
			sda_s_reg <= sda_m_reg;
			sda_d_reg <= sda_s_reg;
			qph_reg   <= qph_reg + 2'h1;
		end
	end

	// generator ticks on the second and fourth quarter of each instruction cycle
	clock_rate_generator u_rate (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.clk_en_i  (clk_en_i),
		.load_i    (brg_load_reg),
		.tick_i    (qph_reg[0]),
		.reload_i  (adr_reg[6:0]),
		.expire_o  (brg_exp)
	);

	// lines we leave high must read high, else another master won
	assign chk_one = (op_reg == OP_ACK) ? !sda_drv_reg :
		(op_reg == OP_TX && bit_cnt_reg < 4'h8 && !sda_drv_reg);
	assign collide = (state_reg == MS_START1 && (!scl_s_reg || !sda_s_reg)) ||
		(state_reg == MS_START2 && !scl_s_reg) ||
		(state_reg == MS_RS1 && brg_exp && !sda_s_reg) ||
		(state_reg == MS_RS_HW && scl_s_reg && !sda_s_reg) ||
		(state_reg == MS_RS2 && (!sda_s_reg || !scl_s_reg)) ||
		(state_reg == MS_RS3 && !scl_s_reg) ||
		(state_reg == MS_BIT_HI && chk_one && !sda_s_reg);

	// master sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg    <= MS_IDLE;
			op_reg       <= OP_TX;
			bit_cnt_reg  <= 4'h0;
			shreg_reg    <= 8'h00;
			scl_drv_reg  <= 1'h0;
			sda_drv_reg  <= 1'h0;
			ack_rcv_reg  <= 1'h0;
			done_reg     <= 1'h0;
			bcol_reg     <= 1'h0;
			brg_load_reg <= 1'h0;
			bf_clr_reg   <= 1'h0;
			rx_load_reg  <= 1'h0;
		end else if (clk_en_i) begin
			done_reg     <= 1'h0;
			bcol_reg     <= 1'h0;
			brg_load_reg <= 1'h0;
			bf_clr_reg   <= 1'h0;
			rx_load_reg  <= 1'h0;
			if (!master_on) begin
				state_reg   <= MS_IDLE;
				scl_drv_reg <= 1'h0;
				sda_drv_reg <= 1'h0;
			end else if (collide) begin
				state_reg   <= MS_IDLE;
				scl_drv_reg <= 1'h0;
				sda_drv_reg <= 1'h0;
				bcol_reg    <= 1'h1;
			end else begin
				case (state_reg)
				MS_IDLE: begin
					if (tx_go) begin
						shreg_reg    <= wdata_i;
						op_reg       <= OP_TX;
						bit_cnt_reg  <= 4'h0;
						scl_drv_reg  <= 1'h1;
						sda_drv_reg  <= !wdata_i[7];
						brg_load_reg <= 1'h1;
						state_reg    <= MS_BIT_LO;
					end else if (!done_reg && !bcol_reg) begin
						if (ctl2_reg[`C2_SEN]) begin
							if (scl_s_reg && sda_s_reg && bus_free) begin
								brg_load_reg <= 1'h1;
								state_reg    <= MS_START1;
							end else begin
								bcol_reg <= 1'h1;
							end
						end else if (ctl2_reg[`C2_REPEAT_START_REQUEST_BIT]) begin
							scl_drv_reg  <= 1'h1;
							sda_drv_reg  <= 1'h0;
							brg_load_reg <= 1'h1;
							state_reg    <= MS_RS1;
						end else if (ctl2_reg[`C2_PEN]) begin
							scl_drv_reg  <= 1'h1;
							sda_drv_reg  <= 1'h1;
							brg_load_reg <= 1'h1;
							state_reg    <= MS_STOP1;
						end else if (ctl2_reg[`C2_RECEIVE_REQUEST_BIT]) begin
							op_reg       <= OP_RX;
							bit_cnt_reg  <= 4'h0;
							scl_drv_reg  <= 1'h1;
							sda_drv_reg  <= 1'h0;
							brg_load_reg <= 1'h1;
							state_reg    <= MS_BIT_LO;
						end else if (ctl2_reg[`C2_ACK_SEND_REQUEST]) begin
							op_reg       <= OP_ACK;
							scl_drv_reg  <= 1'h1;
							sda_drv_reg  <= !ctl2_reg[`C2_ACK_VALUE_TO_SEND];
							brg_load_reg <= 1'h1;
							state_reg    <= MS_BIT_LO;
						end
					end
				end
				MS_START1: begin
					if (brg_exp) begin
						sda_drv_reg  <= 1'h1;
						brg_load_reg <= 1'h1;
						state_reg    <= MS_START2;
					end
				end
				MS_START2, MS_RS3: begin
					if (brg_exp) begin
						done_reg  <= 1'h1;
						state_reg <= MS_IDLE;
					end
				end
				MS_RS1: begin
					if (brg_exp) begin
						scl_drv_reg <= 1'h0;
						state_reg   <= MS_RS_HW;
					end
				end
				MS_RS_HW: begin
					if (scl_s_reg) begin
						brg_load_reg <= 1'h1;
						state_reg    <= MS_RS2;
					end
				end
				MS_RS2: begin
					if (brg_exp) begin
						sda_drv_reg  <= 1'h1;
						brg_load_reg <= 1'h1;
						state_reg    <= MS_RS3;
					end
				end
				MS_BIT_LO: begin
					if (brg_exp) begin
						scl_drv_reg <= 1'h0;
						state_reg   <= MS_BIT_HW;
					end
				end
				MS_BIT_HW: begin
					if (scl_s_reg) begin
						brg_load_reg <= 1'h1;
						state_reg    <= MS_BIT_HI;
					end
				end
				MS_BIT_HI: begin
					if (brg_exp) begin
						scl_drv_reg <= 1'h1;
						if (op_reg == OP_RX)
							shreg_reg <= {shreg_reg[6:0], sda_s_reg};
						if (op_reg == OP_ACK || (op_reg == OP_RX && bit_cnt_reg == 4'h7) ||
							(op_reg == OP_TX && bit_cnt_reg == 4'h8)) begin
							// clock stays low and the generator idles until the next request
							state_reg   <= MS_IDLE;
							done_reg    <= 1'h1;
							rx_load_reg <= (op_reg == OP_RX);
							if (op_reg == OP_TX)
								ack_rcv_reg <= sda_s_reg;
						end else begin
							bit_cnt_reg  <= bit_cnt_reg + 4'h1;
							brg_load_reg <= 1'h1;
							state_reg    <= MS_BIT_LO;
							if (op_reg == OP_TX) begin
								shreg_reg   <= {shreg_reg[6:0], 1'h0};
								sda_drv_reg <= (bit_cnt_reg == 4'h7) ? 1'h0 : !shreg_reg[6];
								bf_clr_reg  <= (bit_cnt_reg == 4'h7);
							end
						end
					end
				end
				MS_STOP1: begin
					if (brg_exp) begin
						scl_drv_reg <= 1'h0;
						state_reg   <= MS_STOP_HW;
					end
				end
				MS_STOP_HW: begin
					if (scl_s_reg) begin
						brg_load_reg <= 1'h1;
						state_reg    <= MS_STOP2;
					end
				end
				MS_STOP2: begin
					if (brg_exp) begin
						sda_drv_reg  <= 1'h0;
						brg_load_reg <= 1'h1;
						state_reg    <= MS_STOP3;
					end
				end
				MS_STOP3: begin
					if (brg_exp) begin
						done_reg  <= 1'h1;
						state_reg <= MS_IDLE;
					end
				end
				default: begin
					state_reg <= MS_IDLE;
				end
				endcase
			end
		end
	end

	// slave address match: own address in bits 7:1, or the fixed general call
	assign own_m = (rsr_reg[7:1] == adr_reg[7:1]);
	assign gc_m  = ctl2_reg[`C2_GENERAL_CALL_ENABLE] && (rsr_reg == `GEN_CALL_ADDR);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsr_reg       <= 8'h00;
			sl_cnt_reg    <= 4'h0;
			sl_active_reg <= 1'h0;
			sl_addr_reg   <= 1'h0;
			sl_ack_reg    <= 1'h0;
			sl_rw_reg     <= 1'h0;
			sl_da_reg     <= 1'h0;
			{sl_load_reg, sl_irq_reg, sl_ov_reg, sl_ua_reg} <= 4'h0;
		end else if (clk_en_i) begin
			{sl_load_reg, sl_irq_reg, sl_ov_reg, sl_ua_reg} <= 4'h0;
			if (!slave_on || stop_det) begin
				sl_active_reg <= 1'h0;
				sl_ack_reg    <= 1'h0;
			end else if (start_det) begin
				sl_active_reg <= 1'h1;
				sl_addr_reg   <= 1'h1;
				sl_cnt_reg    <= 4'h0;
			end else if (sl_active_reg) begin
				if (scl_rise && sl_cnt_reg < 4'h8) begin
					rsr_reg    <= {rsr_reg[6:0], sda_s_reg};
					sl_cnt_reg <= sl_cnt_reg + 4'h1;
				end else if (scl_fall && sl_cnt_reg == 4'h8) begin
					if (sl_addr_reg && !(own_m || gc_m)) begin
						sl_active_reg <= 1'h0;
					end else begin
						sl_cnt_reg  <= 4'h9;
						sl_load_reg <= !stat_reg[`ST_BF];
						sl_ack_reg  <= !stat_reg[`ST_BF] && !ctl1_reg[`C1_OVF];
						sl_ov_reg   <= stat_reg[`ST_BF];
						sl_da_reg   <= !sl_addr_reg;
						if (sl_addr_reg) begin
							sl_rw_reg   <= rsr_reg[0];
							sl_addr_reg <= 1'h0;
							sl_ua_reg   <= (ctl1_reg[3:0] == `MODE_SLAVE10) && !gc_m;
						end
					end
				end else if (scl_fall && sl_cnt_reg == 4'h9) begin
					sl_ack_reg <= 1'h0;
					sl_irq_reg <= 1'h1;
					sl_cnt_reg <= 4'h0;
					if (sl_rw_reg)
						sl_active_reg <= 1'h0;
				end
			end
		end
	end

	// control one and two; hardware sets beat software clears
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl1_reg <= `RST_BYTE;
			ctl2_reg <= `RST_BYTE;
		end else if (clk_en_i) begin
			if (wr_c1)
				ctl1_reg <= wdata_i;
			if (wr_buf && !tx_ok && master_on)
				ctl1_reg[`C1_WRITE_COLLISION_FLAG] <= 1'h1;
			if (sl_ov_reg)
				ctl1_reg[`C1_OVF] <= 1'h1;
			if (wr_c2) begin
				ctl2_reg[`C2_GENERAL_CALL_ENABLE]  <= wdata_i[`C2_GENERAL_CALL_ENABLE];
				ctl2_reg[`C2_ACK_VALUE_TO_SEND] <= wdata_i[`C2_ACK_VALUE_TO_SEND];
				// requests cannot queue behind one already running
				if (tx_ok)
					ctl2_reg[4:0] <= wdata_i[4:0];
			end
			ctl2_reg[`C2_ACK_RECEIVED_STATUS] <= ack_rcv_reg;
			if (done_reg || bcol_reg || !master_on)
				ctl2_reg[4:0] <= 5'h00;
		end
	end

	// status, address and buffer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_reg <= `RST_BYTE;
			adr_reg  <= `RST_BYTE;
			buf_reg  <= 8'h00;
		end else if (clk_en_i) begin
			if (wr_st)
				stat_reg[7:6] <= wdata_i[7:6];
			if (!ctl1_reg[`C1_EN]) begin
				stat_reg[`ST_START] <= 1'h0;
				stat_reg[`ST_STOP]  <= 1'h0;
			end else if (start_det) begin
				stat_reg[`ST_START] <= 1'h1;
				stat_reg[`ST_STOP]  <= 1'h0;
			end else if (stop_det) begin
				stat_reg[`ST_START] <= 1'h0;
				stat_reg[`ST_STOP]  <= 1'h1;
			end
			stat_reg[`ST_RW] <= sl_rw_reg;
			stat_reg[`ST_DA] <= sl_da_reg;
			if (wr_adr) begin
				adr_reg           <= wdata_i;
				stat_reg[`ST_UA] <= 1'h0;
			end
			if (sl_ua_reg)
				stat_reg[`ST_UA] <= 1'h1;
			if (rd_buf || bf_clr_reg)
				stat_reg[`ST_BF] <= 1'h0;
			if (tx_go || rx_load_reg || sl_load_reg)
				stat_reg[`ST_BF] <= 1'h1;
			if (tx_go || (wr_buf && !master_on))
				buf_reg <= wdata_i;
			else if (rx_load_reg)
				buf_reg <= shreg_reg;
			else if (sl_load_reg)
				buf_reg <= rsr_reg;
		end
	end

	// peripheral flags, enables, core register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_reg    <= `RST_BYTE;
			enables_reg  <= `RST_BYTE;
			core_irq_reg <= `RST_BYTE;
		end else if (clk_en_i) begin
			if (wr_i && sel_per && addr_i[7:0] == `OFF_IRQ_FLAGS)
				flags_reg <= wdata_i & `FLAGS_IMPL_MASK;
			if (wr_i && sel_per && addr_i[7:0] == `OFF_IRQ_ENABLES)
				enables_reg <= wdata_i & `FLAGS_IMPL_MASK;
			if (wr_i && addr_i[7:0] == `OFF_CORE_IRQ)
				core_irq_reg <= wdata_i;
			if (done_reg || sl_irq_reg ||
				(stop_det && master_on && state_reg == MS_IDLE))
				flags_reg[`IF_PORT] <= 1'h1;
			if (bcol_reg)
				flags_reg[`IF_COLLISION] <= 1'h1;
		end
	end

	// read port, bus drive, wake
	always_comb begin
		rd_mux = 8'h00;
		if (addr_i[7:0] == `OFF_CORE_IRQ)
			rd_mux = core_irq_reg;
		else if (sel_per && addr_i[7:0] == `OFF_IRQ_FLAGS)
			rd_mux = flags_reg;
		else if (sel_per && addr_i[7:0] == `OFF_IRQ_ENABLES)
			rd_mux = enables_reg;
		else if (sel_ser) begin
			case (addr_i[7:0])
			`OFF_ADDR_RELOAD: rd_mux = adr_reg;
			`OFF_CTRL_ONE:    rd_mux = ctl1_reg;
			`OFF_CTRL_TWO:    rd_mux = ctl2_reg;
			`OFF_STATUS:      rd_mux = stat_reg;
			`OFF_DATA_BUF:    rd_mux = buf_reg;
			default:          rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_reg  <= 8'h00;
			sda_oe_reg <= 1'h0;
			wake_reg   <= 1'h0;
		end else if (clk_en_i) begin
			rdata_reg  <= rd_i ? rd_mux : 8'h00;
			sda_oe_reg <= sda_drv_reg || sl_ack_reg;
			wake_reg   <= sleep_i && flags_reg[`IF_PORT] && enables_reg[`IF_PORT];
		end
	end

endmodule

// File: dv/brg_port_chk_sva.sv
`timescale 1ns/100ps
module brg_port_chk (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [7:0]  rdata_o,
	input  wire logic        sleep_i,
	input  wire logic        wake_o,
	input  wire logic        scl_o,
	input  wire logic        scl_oe_o,
	input  wire logic        sda_o,
	input  wire logic        sda_oe_o
);
	logic [7:0] c1_q;
	logic [7:0] rl_q;
	logic       gc_q;
	logic       ie_q;
	logic [9:0] lo_cnt;
	wire        m_cfg = c1_q[5] && c1_q[3:0] == 4'h8;

	// mirror of software writes; of these fields the port itself alters only control one bits 7:6
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			c1_q <= 8'h00;
			rl_q <= 8'h00;
			gc_q <= 1'b0;
			ie_q <= 1'b0;
		end else if (wr_i) begin
			if (addr_i == 12'h611) c1_q <= wdata_i;
			if (addr_i == 12'h610) rl_q <= wdata_i;
			if (addr_i == 12'h612) gc_q <= wdata_i[7];
			if (addr_i == 12'h411) ie_q <= wdata_i[7];
		end
	end

	// saturates so a long held-low clock cannot wrap into a false short count
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) lo_cnt <= 10'h000;
		else if (!scl_oe_o) lo_cnt <= 10'h000;
		else if (lo_cnt != 10'h3FF) lo_cnt <= lo_cnt + 10'h001;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_master_gate: assert property (!m_cfg [*3] |-> !scl_oe_o)
		else $error("clock pulled outside master mode");
	chk_off_quiet: assert property (!c1_q[5] [*3] |-> !scl_oe_o && !sda_oe_o)
		else $error("line pulled while port disabled");
	chk_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("line driven high");
	chk_low_half: assert property ($fell(scl_oe_o) && m_cfg |-> lo_cnt >= 2 * rl_q[6:0] + 2)
		else $error("clock low phase too short");
	chk_wake_cause: assert property (wake_o |-> $past(sleep_i) && $past(ie_q))
		else $error("wake without sleep and enable");
	chk_reload_back: assert property (rd_i && addr_i == 12'h610 |=> rdata_o == rl_q)
		else $error("reload readback wrong");
	chk_mode_back: assert property (rd_i && addr_i == 12'h611 |=>
		{rdata_o[5], rdata_o[3:0]} == {c1_q[5], c1_q[3:0]})
		else $error("mode readback wrong");
	chk_general_call_enable_back: assert property (rd_i && addr_i == 12'h612 |=> rdata_o[7] == gc_q)
		else $error("call enable readback wrong");
endmodule

bind i2c_master_general_call_brg brg_port_chk i_chk (.sys_clk_i, .rst_n_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .sleep_i, .wake_o, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);

// File: dv/i2c_slave_model.sv
`timescale 1ns/100ps
module i2c_slave_model #(
	parameter logic [6:0] OWN_ADDR = 7'h52
) (
	input  wire logic       clk_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       stretch_i,
	input  wire logic [7:0] tx_i,
	output logic            scl_pull_o = 1'b0,
	output logic            sda_pull_o = 1'b0,
	output logic [7:0]      rx_o = 8'h00
);
	logic       scl_q = 1'b1;
	logic       sda_q = 1'b1;
	logic       sel = 1'b0;
	logic       rw = 1'b0;
	logic       first = 1'b0;
	logic [7:0] sr = 8'h00;
	int         bits = 0;
	int         hold = 0;

	// lines are pulled up, so a released pull reads high on the wire
	always @(posedge clk_i) begin
		scl_q <= scl_i;
		sda_q <= sda_i;
		if (hold > 0) hold <= hold - 1;
		else scl_pull_o <= 1'b0;
		if (scl_i && scl_q && sda_q && !sda_i) begin
			bits <= 0;
			first <= 1'b1;
			sel <= 1'b0;
			sda_pull_o <= 1'b0;
		end else if (scl_i && scl_q && !sda_q && sda_i) begin
			sel <= 1'b0;
			sda_pull_o <= 1'b0;
		end else if (scl_i && !scl_q) begin
			if (bits < 8) sr <= {sr[6:0], sda_i};
			if (bits == 8 && rw && sda_i) sel <= 1'b0;
			bits <= bits + 1;
		end else if (!scl_i && scl_q) begin
			// slow mode: hold every low phase well past the master's own
			if (stretch_i) begin
				scl_pull_o <= 1'b1;
				hold <= 12;
			end
			if (bits == 8) begin
				if (first) begin
					sel <= sr[7:1] == OWN_ADDR;
					rw <= sr[0];
					sda_pull_o <= sr[7:1] == OWN_ADDR;
				end else if (sel && !rw) begin
					rx_o <= sr;
					sda_pull_o <= 1'b1;
				end else sda_pull_o <= 1'b0;
			end else if (bits == 9) begin
				bits <= 0;
				first <= 1'b0;
				sda_pull_o <= sel && rw && !tx_i[7];
			end else sda_pull_o <= sel && rw && !tx_i[7 - bits];
		end
	end
endmodule

// File: dv/tb.sv
`timescale 1ns/100ps
module tb
	import serial_port_pkg::*;
;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        clk_en_i = 1'b1;
	logic [11:0] addr_i = 12'h000;
	byte_t       wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        sleep_i = 1'b0;
	logic        tb_scl = 1'b0;
	logic        tb_sda = 1'b0;
	logic        stretch = 1'b0;
	byte_t       tx_b = 8'h00;
	byte_t       rdata_o, rx_b, d;
	logic        wake_o, scl_o, sda_o, scl_oe_o, sda_oe_o, s_scl, s_sda, ack_b;
	logic [16:0] seed = 17'h1149D;
	logic [11:0] regs [8] = '{12'h407, 12'h410, 12'h411, 12'h610, 12'h611, 12'h612, 12'h613,
		12'h6FF};
	byte_t       sent [$];
	int          err_total = 0;
	int          n_compared = 0;
	wire         scl_i = !(scl_oe_o || tb_scl || s_scl);
	wire         sda_i = !(sda_oe_o || tb_sda || s_sda);

	always #20 sys_clk_i = ~sys_clk_i;

	i2c_master_general_call_brg i_dut (.sys_clk_i, .rst_n_i, .clk_en_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .sleep_i, .wake_o, .scl_i, .scl_o, .scl_oe_o, .sda_i,
		.sda_o, .sda_oe_o);
	i2c_slave_model i_slv (.clk_i(sys_clk_i), .scl_i(scl_i), .sda_i(sda_i), .stretch_i(stretch),
		.tx_i(tx_b), .scl_pull_o(s_scl), .sda_pull_o(s_sda), .rx_o(rx_b));

	function automatic logic [16:0] nxt(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic close_out;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input byte_t seen, input byte_t exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input byte_t v);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// bounded poll: a port that never finishes shows as a mismatch, not a hang
	task automatic op(input logic [11:0] a, input byte_t v);
		int i;
		wr(a, v);
		i = 0;
		d = 8'h00;
		while (!d[7] && i < 400) begin
			rd(12'h410);
			i++;
		end
		chk(d & 8'h80, 8'h80);
		wr(12'h410, 8'h00);
	endtask
	// one half period of the 320 ns link clock
	task automatic bb(input logic s, input logic c);
		@(posedge sys_clk_i);
		tb_sda <= !s;
		tb_scl <= !c;
		repeat (3) @(posedge sys_clk_i);
	endtask
	task automatic bb_byte(input byte_t v);
		for (int k = 7; k >= 0; k--) begin
			bb(v[k], 1'b0);
			bb(v[k], 1'b1);
		end
		bb(1'b1, 1'b0);
		bb(1'b1, 1'b1);
		ack_b = sda_i;
		bb(1'b1, 1'b0);
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk_i);
		err_total++;
		close_out;
	end

	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		foreach (regs[i]) begin
			rd(regs[i]);
			chk(d, 8'h00);
		end
		wr(12'h610, 8'h7E);
		wr(12'h411, 8'h80);
		sleep_i <= 1'b1;
		// plain call, call with enable clear, call in ten-bit mode
		for (int m = 0; m < 3; m++) begin
			wr(12'h611, m == 2 ? 8'h27 : 8'h26);
			wr(12'h612, m == 1 ? 8'h00 : 8'h80);
			bb(1'b1, 1'b1);
			bb(1'b0, 1'b1);
			bb(1'b0, 1'b0);
			bb_byte(8'h00);
			chk({7'h00, ack_b}, {7'h00, m == 1});
			rd(12'h410);
			chk(d & 8'h80, m == 1 ? 8'h00 : 8'h80);
			chk({7'h00, wake_o}, {7'h00, m != 1});
			rd(12'h613);
			chk(d & 8'h03, m == 1 ? 8'h00 : 8'h01);
			rd(12'h614);
			if (m != 1) chk(d, 8'h00);
			wr(12'h410, 8'h00);
			if (m == 2) begin
				seed = nxt(seed);
				bb_byte(seed[7:0]);
				rd(12'h614);
				chk(d, seed[7:0]);
			end
			bb(1'b0, 1'b0);
			bb(1'b0, 1'b1);
			bb(1'b1, 1'b1);
		end
		wr(12'h611, 8'h28);
		sleep_i <= 1'b0;
		wr(12'h610, 8'h01);
		tb_sda <= 1'b1;
		wr(12'h612, 8'h01);
		repeat (20) @(posedge sys_clk_i);
		rd(12'h410);
		chk(d & 8'h40, 8'h40);
		rd(12'h612);
		chk(d & 8'h1F, 8'h00);
		wr(12'h410, 8'h00);
		tb_sda <= 1'b0;
		repeat (20) @(posedge sys_clk_i);
		rd(12'h410);
		chk(d & 8'h80, 8'h80);
		wr(12'h410, 8'h00);
		wr(12'h612, 8'h01);
		wr(12'h614, 8'hA4);
		op(12'h410, 8'h00);
		rd(12'h611);
		chk(d & 8'h80, 8'h80);
		wr(12'h611, 8'h28);
		rd(12'h613);
		chk(d & 8'h18, 8'h08);
		op(12'h614, 8'hA4);
		rd(12'h612);
		chk(d & 8'h40, 8'h00);
		stretch <= 1'b1;
		seed = nxt(seed);
		sent.push_back(seed[7:0]);
		op(12'h614, seed[7:0]);
		rd(12'h613);
		chk(d & 8'h01, 8'h00);
		chk(rx_b, sent.pop_front());
		op(12'h612, 8'h02);
		// the slave puts out its first bit on the clock fall that ends its address ack
		seed = nxt(seed);
		tx_b <= seed[7:0];
		op(12'h614, 8'hA5);
		rd(12'h612);
		chk(d & 8'h40, 8'h00);
		op(12'h612, 8'h08);
		rd(12'h614);
		chk(d, tx_b);
		op(12'h612, 8'h30);
		op(12'h612, 8'h04);
		rd(12'h613);
		chk(d & 8'h18, 8'h10);
		wr(12'h611, 8'h00);
		rd(12'h613);
		chk(d & 8'h18, 8'h00);
		close_out;
	end
endmodule
